//--- design/ext_bus_pin_mux_pkg.sv
/*
  Constants and types for the external bus pin multiplexer.
  Assumes one clock domain and a single user of this package.
*/
package ext_bus_pin_mux_pkg;
  // pin vector layout: port A pins 0..7, port B pin 0, port F pins 9..15
  localparam int NUM_PINS      = 16;
  localparam int PA_LSB        = 0;
  localparam int PA_WIDTH      = 8;
  localparam int PB0_POS       = 8;
  localparam int PF_LSB        = 9;
  localparam int PF_WIDTH      = 7;
  localparam int CTRL_WIDTH    = 3;
  localparam int CFG_WIDTH     = 8;

  // configuration port selectors
  localparam logic [2:0] SEL_PA_PER = 3'h0;
  localparam logic [2:0] SEL_PB_PER = 3'h1;
  localparam logic [2:0] SEL_PF_PER = 3'h2;
  localparam logic [2:0] SEL_PA_PUR = 3'h3;
  localparam logic [2:0] SEL_PB_PUR = 3'h4;
  localparam logic [2:0] SEL_PF_PUR = 3'h5;

  // reset values
  localparam logic [7:0] PA_PER_RST = 8'hff;
  localparam logic       PB_PER_RST = 1'h0;
  localparam logic [6:0] PF_PER_RST = 7'h7f;
  localparam logic [7:0] PA_PUR_RST = 8'hff;
  localparam logic       PB_PUR_RST = 1'h1;
  localparam logic [6:0] PF_PUR_RST = 7'h7f;

  typedef enum logic {ST_STRAP, ST_RUN} mux_state_t;
endpackage

//--- design/ext_bus_pin_mux.sv
/*
  Pin multiplexer for the upper address lines, address bit 16 and the
  low data lines shared between the external memory interface and the
  general purpose ports.
  Assumes all inputs are synchronous to mclk_i and that pad wires are
  resolved outside from the output and output-enable vectors.
*/
`timescale 1ns/1ps
module ext_bus_pin_mux (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        bus_drive_keep_i,
  input  wire logic        mem_if_access_active_i,
  input  wire logic [16:8] mem_if_addr_i,
  input  wire logic [6:0]  mem_if_data_out_i,
  input  wire logic        mem_if_data_oe_i,
  input  wire logic [2:0]  mem_if_ctrl_i,
  output logic      [6:0]  mem_if_data_in_o,
  input  wire logic        external_boot_select_i,
  input  wire logic        ext_mem_if_mode_pin_i,
  input  wire logic        flash_secure_i,
  input  wire logic        cfg_we_i,
  input  wire logic [2:0]  cfg_sel_i,
  input  wire logic [7:0]  cfg_wdata_i,
  input  wire logic [15:0] gpio_out_i,
  input  wire logic [15:0] gpio_dir_i,
  output logic      [15:0] gpio_in_o,
  output logic      [15:0] periph_en_o,
  output logic      [15:0] pullup_en_o,
  input  wire logic [15:0] pad_i,
  output logic      [15:0] pad_o,
  output logic      [15:0] pad_oe_o,
  output logic      [2:0]  ctrl_pad_o,
  output logic      [2:0]  ctrl_pad_oe_o
);

  typedef struct packed {
    ext_bus_pin_mux_pkg::mux_state_t st;
    logic [15:0] per;
    logic [15:0] pur;
    logic [15:0] pad;
    logic [15:0] pad_oe;
    logic [15:0] gin;
    logic [2:0]  ctrl;
    logic        ctrl_oe;
  } mux_regs_t;

  mux_regs_t s_q;
  mux_regs_t s_d;

  logic        strap_addr;
  logic        addr_oe;
  logic        data_oe;
  logic [15:0] bus_val;
  logic [15:0] bus_oe;

  // reset-time choice for port B pin 0; external boot always needs the
  // address bit, and a secured flash keeps it as a port pin otherwise
  assign strap_addr = external_boot_select_i |
                      (ext_mem_if_mode_pin_i & ~flash_secure_i);

  // address and control stay driven only during an access unless the
  // keep bit asks for them between accesses too
  assign addr_oe = mem_if_access_active_i | bus_drive_keep_i;
  // data lines must turn round for reads, so during an access the
  // interface decides; between accesses only the keep bit drives them
  assign data_oe = mem_if_access_active_i ? mem_if_data_oe_i
                                          : bus_drive_keep_i;

  assign bus_val = {mem_if_data_out_i, mem_if_addr_i};
  assign bus_oe  = {{ext_bus_pin_mux_pkg::PF_WIDTH{data_oe}},
                    {(ext_bus_pin_mux_pkg::PA_WIDTH + 1){addr_oe}}};

  // next state: strap capture, configuration writes, pad steering
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ext_bus_pin_mux_pkg::ST_STRAP: begin
        s_d.per[ext_bus_pin_mux_pkg::PB0_POS] = strap_addr;
        s_d.st = ext_bus_pin_mux_pkg::ST_RUN;
      end
      ext_bus_pin_mux_pkg::ST_RUN: begin
        s_d.st = ext_bus_pin_mux_pkg::ST_RUN;
      end
      default: begin
        s_d.st = ext_bus_pin_mux_pkg::ST_RUN;
      end
    endcase
    // a SEL_PB_PER write in the strap cycle overrides the strap choice
    if (cfg_we_i) begin
      case (cfg_sel_i)
        ext_bus_pin_mux_pkg::SEL_PA_PER: s_d.per[7:0] = cfg_wdata_i;
        ext_bus_pin_mux_pkg::SEL_PB_PER: begin
          s_d.per[ext_bus_pin_mux_pkg::PB0_POS] = cfg_wdata_i[0];
        end
        ext_bus_pin_mux_pkg::SEL_PF_PER: s_d.per[15:9] = cfg_wdata_i[6:0];
        ext_bus_pin_mux_pkg::SEL_PA_PUR: begin
          s_d.pur[7:0] = cfg_wdata_i;
        end
        ext_bus_pin_mux_pkg::SEL_PB_PUR: begin
          s_d.pur[ext_bus_pin_mux_pkg::PB0_POS] = cfg_wdata_i[0];
        end
        ext_bus_pin_mux_pkg::SEL_PF_PUR: begin
          s_d.pur[15:9] = cfg_wdata_i[6:0];
        end
        default: ;
      endcase
    end
    // each pin follows the bus or its own port direction and value
    for (int k = 0; k < ext_bus_pin_mux_pkg::NUM_PINS; k++) begin
      if (s_q.per[k]) begin
        s_d.pad[k]    = bus_val[k];
        s_d.pad_oe[k] = bus_oe[k];
      end else begin
        s_d.pad[k]    = gpio_out_i[k];
        s_d.pad_oe[k] = gpio_dir_i[k];
      end
    end
    s_d.gin     = pad_i;
    s_d.ctrl    = mem_if_ctrl_i;
    s_d.ctrl_oe = addr_oe;
  end

  // one register for all state; ce_i low freezes everything
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.st      <= ext_bus_pin_mux_pkg::ST_STRAP;
      s_q.per     <= {ext_bus_pin_mux_pkg::PF_PER_RST,
                      ext_bus_pin_mux_pkg::PB_PER_RST,
                      ext_bus_pin_mux_pkg::PA_PER_RST};
      s_q.pur     <= {ext_bus_pin_mux_pkg::PF_PUR_RST,
                      ext_bus_pin_mux_pkg::PB_PUR_RST,
                      ext_bus_pin_mux_pkg::PA_PUR_RST};
      s_q.pad     <= 16'h0000;
      s_q.pad_oe  <= 16'h0000;
      s_q.gin     <= 16'h0000;
      s_q.ctrl    <= 3'h0;
      s_q.ctrl_oe <= 1'b0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign pad_o         = s_q.pad;
  assign pad_oe_o      = s_q.pad_oe;
  assign ctrl_pad_o    = s_q.ctrl;
  assign ctrl_pad_oe_o = {ext_bus_pin_mux_pkg::CTRL_WIDTH{s_q.ctrl_oe}};
  assign gpio_in_o     = s_q.gin;
  assign mem_if_data_in_o = s_q.gin[15:9];
  assign periph_en_o   = s_q.per;
  assign pullup_en_o   = s_q.pur;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence idle_no_keep_s;
    ce_i && !bus_drive_keep_i && !mem_if_access_active_i;
  endsequence

  sequence keep_idle_s;
    ce_i && bus_drive_keep_i && !mem_if_access_active_i;
  endsequence

  chk_addr_idle_release: assert property (
    idle_no_keep_s ##0 periph_en_o[0] |=> !pad_oe_o[0] && !ctrl_pad_oe_o[0])
    else $error("address or control driven on idle bus");

  chk_data_idle_release: assert property (
    idle_no_keep_s ##0 periph_en_o[9] |=> !pad_oe_o[9])
    else $error("data line driven on idle bus");

  chk_keep_drive_idle: assert property (
    keep_idle_s ##0 periph_en_o[0] && periph_en_o[9]
    |=> pad_oe_o[0] && pad_oe_o[9] && pad_o[15:9] == $past(mem_if_data_out_i))
    else $error("lines not held while keep bit set");

  chk_reset_defaults: assert property (
    s_q.st == ext_bus_pin_mux_pkg::ST_STRAP
    |-> periph_en_o[7:0] == 8'hff && periph_en_o[15:9] == 7'h7f)
    else $error("shared pins not on bus after reset");

  chk_strap_pick: assert property (
    s_q.st == ext_bus_pin_mux_pkg::ST_STRAP && ce_i && !cfg_we_i
    |=> periph_en_o[8] == $past(strap_addr)
        && s_q.st == ext_bus_pin_mux_pkg::ST_RUN)
    else $error("port B pin 0 strap not applied");

  chk_pb_per_write: assert property (
    ce_i && cfg_we_i && cfg_sel_i == ext_bus_pin_mux_pkg::SEL_PB_PER
    |=> periph_en_o[8] == $past(cfg_wdata_i[0]))
    else $error("port B pin 0 function write lost");

  chk_pullup_write: assert property (
    ce_i && cfg_we_i && cfg_sel_i == ext_bus_pin_mux_pkg::SEL_PA_PUR
    |=> pullup_en_o[7:0] == $past(cfg_wdata_i))
    else $error("port A pull-up write lost");

  chk_gpio_direction: assert property (
    ce_i |=> (pad_oe_o & ~$past(periph_en_o))
             == ($past(gpio_dir_i) & ~$past(periph_en_o)))
    else $error("port pin direction not followed");

  chk_data_read_turn: assert property (
    ce_i && mem_if_access_active_i && !mem_if_data_oe_i && periph_en_o[9]
    |=> !pad_oe_o[9])
    else $error("data line driven during read");

  // control pins carry the interface value one stage late
  chk_ctrl_follow: assert property (
    ce_i |=> ctrl_pad_o == $past(mem_if_ctrl_i))
    else $error("control pins do not follow interface");

  // read data seen by the interface is the registered pad level
  chk_data_capture: assert property (
    ce_i |=> mem_if_data_in_o == $past(pad_i[15:9]))
    else $error("data pins not captured for interface");

  chk_pb_pullup_write: assert property (
    ce_i && cfg_we_i && cfg_sel_i == ext_bus_pin_mux_pkg::SEL_PB_PUR
    |=> pullup_en_o[8] == $past(cfg_wdata_i[0]))
    else $error("port B pull-up write lost");

  // data pins stay on the bus until a port F enable write
  chk_data_default: assert property (
    s_q.st == ext_bus_pin_mux_pkg::ST_STRAP |-> periph_en_o[15:9] == 7'h7f)
    else $error("data pins not on bus after reset");

endmodule

//--- tb/ext_mem_model.sv
/*
  external memory and pad wire model: resolves each pad from the mux
  drive, a memory read on the data pins, a pull-up, or nothing.
  assumes the bench steers reads through rd_en_i.
*/
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic [15:0] pad_o,
  input  wire logic [15:0] pad_oe_o,
  input  wire logic [15:0] pullup_en_o,
  input  wire logic        rd_en_i,
  input  wire logic [6:0]  rd_data_i,
  output logic      [15:0] lvl_o
);
  logic [15:0] rdv;
  assign rdv = {rd_data_i, 9'h0};
  // floating pins show the inverse of pad_o, not a lucky level
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_oe_o[i]) lvl_o[i] = pad_o[i];
      else if (i > 8 && rd_en_i) lvl_o[i] = rdv[i];
      else if (pullup_en_o[i]) lvl_o[i] = 1'h1;
      else lvl_o[i] = ~pad_o[i];
    end
  end
endmodule

//--- tb/tb_top.sv
/*
  bench for the external bus pin multiplexer: straps, idle release,
  reads, function moves and pull-ups.
  assumes one register stage from inputs to pads.
*/
`timescale 1ns/1ps
module tb_top;
  logic        mclk_i = 0, rst_i = 1, ce_i = 1, keep = 0, act = 0;
  logic        doe = 0, boot = 0, mode = 0, sec = 0, we = 0, rd_en = 0;
  logic [16:8] addr = 9'h1a5;
  logic [6:0]  dout = 7'h55, rd_data = 7'h2b, din;
  logic [2:0]  ctrl = 3'h5, sel = 3'h0, ctrl_o, ctrl_oe;
  logic [7:0]  wdata = 8'h0;
  logic [15:0] gout = 16'h0, gdir = 16'h0, gin, pen, pue, lvl, po, poe;
  int          error_cnt = 0;
  int          tests_run = 0;
  always #12.5 mclk_i = ~mclk_i;
  ext_bus_pin_mux u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .bus_drive_keep_i(keep), .mem_if_access_active_i(act),
    .mem_if_addr_i(addr), .mem_if_data_out_i(dout), .mem_if_data_oe_i(doe),
    .mem_if_ctrl_i(ctrl), .mem_if_data_in_o(din),
    .external_boot_select_i(boot),
    .ext_mem_if_mode_pin_i(mode), .flash_secure_i(sec), .cfg_we_i(we),
    .cfg_sel_i(sel), .cfg_wdata_i(wdata), .gpio_out_i(gout),
    .gpio_dir_i(gdir), .gpio_in_o(gin), .periph_en_o(pen),
    .pullup_en_o(pue), .pad_i(lvl), .pad_o(po), .pad_oe_o(poe),
    .ctrl_pad_o(ctrl_o), .ctrl_pad_oe_o(ctrl_oe));
  ext_mem_model u_mem (.pad_o(po), .pad_oe_o(poe), .pullup_en_o(pue),
    .rd_en_i(rd_en), .rd_data_i(rd_data), .lvl_o(lvl));
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // settle one past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic cfg(input logic [2:0] s, input logic [7:0] d);
    we <= 1'h1;
    sel <= s;
    wdata <= d;
    cyc(1);
    we <= 1'h0;
    cyc(2);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // every strap combination, each through a full reset
  initial begin
    for (int i = 0; i < 8; i++) begin
      rst_i <= 1'h1;
      boot <= i[0];
      mode <= i[1];
      sec <= i[2];
      cyc(2);
      chk("reset func", 16'hfeff, pen);
      chk("reset oe", 16'h0, poe);
      rst_i <= 1'h0;
      cyc(3);
      chk("strap", {7'h7f, i[0] | (i[1] & ~i[2]), 8'hff}, pen);
    end
    chk("idle oe", 16'h0, poe);
    chk("ctrl oe", 16'h0, {13'h0, ctrl_oe});
    keep <= 1'h1;
    cyc(3);
    chk("keep oe", 16'hffff, poe);
    chk("keep pad", {7'h55, 9'h1a5}, po);
    chk("ctrl", 16'h7005, {1'h0, ctrl_oe, 9'h0, ctrl_o});
    // slow read: memory answers a cycle after the access opens
    keep <= 1'h0;
    act <= 1'h1;
    cyc(1);
    rd_en <= 1'h1;
    cyc(3);
    chk("read oe", 16'h01ff, poe);
    chk("read data", {9'h0, rd_data}, {9'h0, din});
    act <= 1'h0;
    rd_en <= 1'h0;
    keep <= 1'h1;
    cfg(ext_bus_pin_mux_pkg::SEL_PB_PER, 8'h0);
    chk("pb port", 16'hfeff, poe);
    cfg(ext_bus_pin_mux_pkg::SEL_PB_PER, 8'h1);
    chk("pb addr", 16'hffff, pen);
    // all pins to port use with a mixed direction pattern
    gdir <= 16'ha5c3;
    gout <= 16'h3c5a;
    cfg(ext_bus_pin_mux_pkg::SEL_PA_PER, 8'h0);
    cfg(ext_bus_pin_mux_pkg::SEL_PB_PER, 8'h0);
    cfg(ext_bus_pin_mux_pkg::SEL_PF_PER, 8'h0);
    chk("port oe", 16'ha5c3, poe);
    chk("port out", 16'h3c5a & 16'ha5c3, po & 16'ha5c3);
    chk("port in", 16'h3c5a | 16'h5a3c, gin);
    cfg(ext_bus_pin_mux_pkg::SEL_PA_PUR, 8'hfe);
    chk("pa pull", 16'hfffe, pue);
    cfg(ext_bus_pin_mux_pkg::SEL_PF_PUR, 8'h0);
    cfg(ext_bus_pin_mux_pkg::SEL_PB_PUR, 8'h0);
    cfg(3'h6, 8'h0);
    chk("pf pb pull", 16'h00fe, pue);
    finish_test();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    finish_test();
  end
endmodule
